// ---- hw/fp_coproc_data_transfer.sv ----
// Decoder and sequencer for floating-point coprocessor data transfer instructions
//
// Contract
// - Single transfer moves one register in five formats; load bit 1 loads, 0 stores.
// - Single store rounds to destination precision with round-to-nearest.
// - Index bit 1 applies offset before transfer; 0 applies it after.
// - Direction bit 1 adds offset, 0 subtracts it.
// - Offset is unsigned 8-bit field bits 7..0, counted in words.
// - Write-back bit 1 writes modified base back; 0 keeps base.
// - Post-indexing never implies write-back; only the explicit bit does.
// - Bits 22,15 plus expanded flag pick length of 1,2,3,3 or 4 words.
// - First word address is base, offset-modified when pre-indexed.
// - Each later word address rises by 4 bytes whatever the direction.
// - Multi transfer moves one to four registers in one operation.
// - Multi transfer recognised only with coprocessor number 2 in bits 11..8.
// - Multi transfer moves three memory words per register.
// - Unimplemented instructions are left to host software emulation.
// - Multi count bits 22,15: 01 one, 10 two, 11 three, 00 four.
// - Registers go in ascending order from named one, wrapping seven to zero.
`timescale 1ns/1ns
`include "fp_xfer_defines.svh"

module fp_coproc_data_transfer #(
    parameter int REG_COUNT = 8
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic                instrValid,
    input  wire logic [31:0]         instr,
    input  wire logic [31:0]         baseValue,
    input  wire logic                expanded_packed_flag,
    output logic                     instrReady,
    output logic                     instrAccepted,
    output logic                     instrBounce,
    output logic                     reqValid,
    input  wire logic                reqReady,
    output fp_xfer_pkg::mem_req_s    req,
    output logic                     roundNearest,
    output logic [2:0]               singleFormat,
    output logic                     multiFormat,
    output logic                     baseWbValid,
    output fp_xfer_pkg::base_wb_s    baseWb,
    output logic                     done
);
    import fp_xfer_pkg::*;

    xfer_state_e state;
    logic [3:0]  wordsLeft;
    logic [1:0]  wordInReg;
    logic        isMulti;
    logic        isSingle;
    logic [31:0] disp;
    logic [31:0] modBase;
    logic [3:0]  totalWords;
    logic [2:0]  fmtCode;
    logic [31:0] xferAddr;
    logic        xferLoad;
    logic [2:0]  fpRegCur;
    logic        wordTaken;
    logic        lastWord;
    logic        lastInReg;

    // Index of the third word of a register in a multi transfer
    localparam logic [1:0] LAST_WORD_IN_REG = 2'(`WORDS_PER_REG - 3'h1);

    // Byte displacement: word offset times four, shared by both instruction kinds
    function automatic logic [31:0] word_disp(input logic [7:0] off);
        word_disp = {22'h0, off, 2'h0};
    endfunction

    // Base plus or minus displacement
    function automatic logic [31:0] apply_offset(input logic [31:0] base, input logic [31:0] d, input logic up);
        apply_offset = up ? base + d : base - d;
    endfunction

    // Data transfer class carrying the given coprocessor number
    function automatic logic match_xfer(input logic [31:0] word, input logic [3:0] cpNum);
        match_xfer = (word[`CLASS_MSB:`CLASS_LSB] == `CLASS_XFER) && (word[`CPNUM_MSB:`CPNUM_LSB] == cpNum);
    endfunction

    // Class decode; other coprocessor numbers bounce to software emulation
    assign isSingle = match_xfer(instr, `CPNUM_SINGLE);
    assign isMulti  = match_xfer(instr, `CPNUM_MULTI);
    assign disp     = word_disp(instr[`OFFSET_MSB:0]);
    assign modBase  = apply_offset(baseValue, disp, instr[`UP_BIT]);

    // Length decode for both kinds
    always_comb begin
        fmtCode    = {1'h0, instr[`LEN_HIGH_BIT], instr[`LEN_LOW_BIT]};
        totalWords = 4'h0;
        if (isMulti) begin
            // Count 00 means four registers, three words each
            case ({instr[`LEN_HIGH_BIT], instr[`LEN_LOW_BIT]})
                2'h1:    totalWords = 4'h3;
                2'h2:    totalWords = 4'h6;
                2'h3:    totalWords = 4'h9;
                default: totalWords = 4'hC;
            endcase
        end else begin
            case ({instr[`LEN_HIGH_BIT], instr[`LEN_LOW_BIT]})
                2'h0:    totalWords = 4'h1;
                2'h1:    totalWords = 4'h2;
                2'h2:    totalWords = 4'h3;
                default: begin
                    // Packed decimal grows by one word when the expanded flag is set
                    totalWords = expanded_packed_flag ? 4'h4 : 4'h3;
                    fmtCode    = expanded_packed_flag ? 3'h4 : 3'h3;
                end
            endcase
        end
    end

    assign instrReady    = (state == ST_IDLE);
    assign instrAccepted = instrReady && instrValid && (isSingle || isMulti);
    assign instrBounce   = instrReady && instrValid && !(isSingle || isMulti);
    assign reqValid      = (state == ST_XFER);

    // Sequencer state; DONE is one quiet cycle before the next instruction can be taken
    always_ff @(posedge clk) begin
        if (srst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (instrAccepted) begin
                        state <= ST_XFER;
                    end
                end
                ST_XFER: begin
                    if (wordTaken && lastWord) begin
                        state <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // One word leaves on every edge where the memory side takes it
    assign wordTaken = reqValid && reqReady;
    assign lastWord  = (wordsLeft == 4'h1);
    assign lastInReg = multiFormat && (wordInReg == LAST_WORD_IN_REG);

    // Next register in ascending order; wraps at the top of the register file
    function automatic logic [2:0] next_fp_reg(input logic [2:0] cur);
        next_fp_reg = (cur == 3'(REG_COUNT - 1)) ? 3'h0 : cur + 3'h1;
    endfunction

    // Transfer address: first word from the indexed base, then one word up each time
    always_ff @(posedge clk) begin
        if (srst) begin
            xferAddr <= 32'h0;
        end else if (instrAccepted) begin
            xferAddr <= instr[`IDX_BIT] ? modBase : baseValue;
        end else if (wordTaken) begin
            // Always upwards; the direction bit only steers the base offset
            xferAddr <= xferAddr + `WORD_BYTES;
        end
    end

    // Operation flags, latched once per instruction and held for the whole transfer
    always_ff @(posedge clk) begin
        if (srst) begin
            xferLoad     <= 1'h0;
            roundNearest <= 1'h0;
            singleFormat <= 3'h0;
            multiFormat  <= 1'h0;
        end else if (instrAccepted) begin
            xferLoad     <= instr[`LOAD_BIT];
            // Only a single store rounds; multi images are raw register contents
            roundNearest <= isSingle && !instr[`LOAD_BIT];
            singleFormat <= isSingle ? fmtCode : 3'h0;
            multiFormat  <= isMulti;
        end
    end

    // Words still owed to memory; the sequencer leaves XFER on the last one
    always_ff @(posedge clk) begin
        if (srst) begin
            wordsLeft <= 4'h0;
        end else if (instrAccepted) begin
            wordsLeft <= totalWords;
        end else if (wordTaken) begin
            wordsLeft <= wordsLeft - 4'h1;
        end
    end

    // Register number and word position inside that register
    always_ff @(posedge clk) begin
        if (srst) begin
            fpRegCur  <= 3'h0;
            wordInReg <= 2'h0;
        end else if (instrAccepted) begin
            fpRegCur  <= instr[`FPREG_MSB:`FPREG_LSB];
            wordInReg <= 2'h0;
        end else if (wordTaken) begin
            if (lastInReg) begin
                // Third word done: move on to the next register
                fpRegCur  <= next_fp_reg(fpRegCur);
                wordInReg <= 2'h0;
            end else begin
                // Single transfers simply count their words, up to four
                wordInReg <= wordInReg + 2'h1;
            end
        end
    end

    // Request word assembled from the position registers, so it stays a flip-flop output
    assign req = '{addr: xferAddr, load: xferLoad, fpReg: fpRegCur, wordIdx: wordInReg};

    // Base write-back only on explicit bit, never implied by post-indexing
    always_ff @(posedge clk) begin
        if (srst) begin
            baseWbValid <= 1'h0;
            baseWb      <= '0;
        end else begin
            baseWbValid <= instrAccepted && instr[`WB_BIT];
            if (instrAccepted) begin
                // Offset-modified base whatever the indexing mode; the strobe decides its use
                baseWb.baseRegister <= instr[`BASE_MSB:`BASE_LSB];
                baseWb.value        <= modBase;
            end
        end
    end

    // End pulse, one cycle long, as the sequencer is back in idle
    always_ff @(posedge clk) begin
        if (srst) begin
            done <= 1'h0;
        end else begin
            done <= (state == ST_DONE);
        end
    end
endmodule

// ---- hw/fp_xfer_defines.svh ----
// Constants for the floating-point data transfer decoder: fields, codes and counts
`ifndef FP_XFER_DEFINES_SVH
`define FP_XFER_DEFINES_SVH
`define IDX_BIT          24
`define UP_BIT           23
`define LEN_HIGH_BIT     22
`define WB_BIT           21
`define LOAD_BIT         20
`define BASE_MSB         19
`define BASE_LSB         16
`define LEN_LOW_BIT      15
`define FPREG_MSB        14
`define FPREG_LSB        12
`define CPNUM_MSB        11
`define CPNUM_LSB        8
`define OFFSET_MSB       7
`define CLASS_MSB        27
`define CLASS_LSB        25
`define CLASS_XFER       3'h6
`define CPNUM_SINGLE     4'h1
`define CPNUM_MULTI      4'h2
`define WORDS_PER_REG    3'h3
`define WORD_BYTES       32'h4
`endif

// ---- hw/fp_xfer_pkg.sv ----
// Types shared by the floating-point data transfer decoder
package fp_xfer_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_XFER = 2'h1,
        ST_DONE = 2'h3
    } xfer_state_e;

    // One memory word request to the host memory path
    typedef struct packed {
        logic [31:0] addr;
        logic        load;
        logic [2:0]  fpReg;
        logic [1:0]  wordIdx;
    } mem_req_s;

    // Base register update returned to the host core
    typedef struct packed {
        logic [3:0]  baseRegister;
        logic [31:0] value;
    } base_wb_s;
endpackage

// ---- test/fp_xfer_props.sv ----
// Port checks for the data transfer decoder
`timescale 1ns/1ns
module fp_xfer_props (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic [31:0]           instr,
    input wire logic [31:0]           baseValue,
    input wire logic                  instrAccepted,
    input wire logic                  reqValid,
    input wire logic                  reqReady,
    input wire fp_xfer_pkg::mem_req_s req,
    input wire logic                  roundNearest,
    input wire logic                  multiFormat,
    input wire logic                  baseWbValid,
    input wire fp_xfer_pkg::base_wb_s baseWb
);
    import fp_xfer_pkg::*;
    logic [31:0] modBase;
    logic [31:0] firstAddr;
    // Word offset scaled to bytes, then added or taken away
    assign modBase = instr[23] ? baseValue + {instr[7:0], 2'h0} : baseValue - {instr[7:0], 2'h0};
    assign firstAddr = instr[24] ? modBase : baseValue;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    a_accept_class: assert property (instrAccepted |-> instr[27:25] == 3'h6 && (instr[11:8] == 4'h1 || instr[11:8] == 4'h2))
        else $error("accepted a foreign instruction");
    a_wb_explicit: assert property (instrAccepted |=> baseWbValid == $past(instr[21]))
        else $error("write-back does not follow its bit");
    a_wb_value: assert property (instrAccepted && instr[21] |=> baseWb.value == $past(modBase))
        else $error("wrong written-back base");
    a_first_addr: assert property (instrAccepted |=> reqValid && req.addr == $past(firstAddr))
        else $error("wrong first address");
    a_addr_step: assert property (reqValid && reqReady ##1 reqValid |-> req.addr == $past(req.addr) + 32'h4)
        else $error("address step is not one word");
    a_req_hold: assert property (reqValid && !reqReady |=> reqValid && $stable(req))
        else $error("request dropped while stalled");
    a_multi_flag: assert property (instrAccepted |=> multiFormat == $past(instr[9]))
        else $error("multi flag wrong");
    a_round_store: assert property (instrAccepted |=> roundNearest == ($past(instr[8]) && !$past(instr[20])))
        else $error("rounding flag wrong");
endmodule

// ---- test/mem_partner.sv ----
// Memory side model taking transfer words with random stalls
`timescale 1ns/1ns
module mem_partner (
    input  wire logic clk,
    output logic      reqReady
);
    // Stalls one cycle in three so held requests are seen; stored images stay opaque
    initial begin
        reqReady = 1'h0;
        forever begin
            @(posedge clk);
            reqReady <= #1 $urandom_range(2) != 0;
        end
    end
endmodule

// ---- test/test_fp_coproc_data_transfer.sv ----
// Self-checking bench for the data transfer decoder
`timescale 1ns/1ns
module test_fp_coproc_data_transfer;
    import fp_xfer_pkg::*;
    logic        clk, srst, instrValid, expanded_packed_flag, instrReady, instrAccepted, instrBounce;
    logic        reqValid, reqReady, roundNearest, multiFormat, baseWbValid, done;
    logic [31:0] instr, baseValue;
    logic [2:0]  singleFormat;
    mem_req_s    req;
    base_wb_s    baseWb;
    logic [38:0] expQ[$];
    int          mismatches, checkCount;
    fp_coproc_data_transfer dut (.*);
    mem_partner mem (.*);
    task check(input logic [63:0] seen, input logic [63:0] exp);
        checkCount++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", checkCount, mismatches);
        if (mismatches == 0 && checkCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Offer one instruction, note its words, wait for the end
    task run(input logic [31:0] ins);
        logic [31:0] modB;
        logic        acc, multi;
        int          fmt, words, n;
        multi = ins[11:8] == 4'h2;
        acc = ins[27:25] == 3'h6 && (multi || ins[11:8] == 4'h1);
        modB = ins[23] ? baseValue + {ins[7:0], 2'h0} : baseValue - {ins[7:0], 2'h0};
        fmt = {ins[22], ins[15]} + (ins[22] && ins[15] && expanded_packed_flag);
        words = !acc ? 0 : multi ? 3 * (({ins[22], ins[15]} + 3) % 4 + 1) : fmt + (fmt < 3);
        for (int i = 0; i < words; i++)
            expQ.push_back({multi, (ins[24] ? modB : baseValue) + 32'(4 * i), ins[20],
                3'(ins[14:12] + (multi ? i / 3 : 0)), 2'(i % 3)});
        instr = ins;
        instrValid = 1'b1;
        #1 check({instrReady, instrAccepted, instrBounce}, {1'h1, acc, !acc});
        @(posedge clk);
        #1 instrValid = 1'b0;
        if (acc) check({baseWbValid, multiFormat, roundNearest}, {ins[21], multi, !multi && !ins[20]});
        check({instrReady, reqValid}, {!acc, acc});
        if (acc && ins[21]) check(baseWb, {ins[19:16], modB});
        if (acc && !multi) check(singleFormat, fmt);
        for (n = 0; n < 300 && (acc ? done !== 1'b1 : n == 0); n++) // A bounce still lets one edge pass
            @(posedge clk) #1;
        check({n < 300, expQ.size()}, {1'b1, 32'h0});
    endtask
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Each accepted word is compared with the oldest note
    always @(posedge clk) begin
        if (!srst && reqValid && reqReady) begin
            if (expQ.size() == 0) check(1, 0);
            else check(expQ[0][38] ? req : req[37:2], expQ[0][38] ? expQ[0][37:0] : expQ[0][37:2]);
            if (expQ.size() > 0) expQ.delete(0);
        end
    end
    initial begin
        #40000;
        mismatches++;
        stop_test;
    end
    initial begin
        logic [31:0] ins;
        {srst, instrValid, expanded_packed_flag, instr, baseValue} = {3'h4, 64'h0};
        {mismatches, checkCount} = 64'h0;
        void'($urandom(32'h7AF14A4A));
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
        for (int k = 0; k < 48; k++) begin
            ins = $urandom; // Any 8-bit word offset stays within 1020 bytes either way
            ins[27:25] = k % 10 == 7 ? 3'h7 : 3'h6; // Foreign class now and then
            ins[19] = 1'b0;
            {ins[22], ins[15], expanded_packed_flag} = 3'(k >> 2);
            ins[11:8] = k % 12 == 11 ? 4'h3 : k % 3 == 2 ? 4'h2 : 4'h1;
            baseValue = $urandom;
            run(ins);
        end
        stop_test;
    end
endmodule
bind fp_coproc_data_transfer fp_xfer_props props (.*);
